// *** inc/exec_pkg.sv ***
// constants for the jump and increment execute block
// Contract
// - a jump instruction whose top three bits are 101 loads its 9-bit immediate into pc bits 8:0.
// - the same jump fills pc bits 10:9 from status bits 6:5.
// - the jump is always taken and takes two cycles because the fetched instruction is flushed.
// - add_one_to_file (0010 10df ffff) adds one to the file register and writes w when d is 0.
// - for both increments a d of 1 writes the sum back to the same file register, w untouched; file_we comes a cycle later, with the next slot's file_addr.
// - add_one_skip_on_zero (0011 11df ffff) increments, writes its destination and tests for zero.
// - a zero result of add_one_skip_on_zero flushes the fetched instruction, taking two cycles.
package exec_pkg;
	localparam logic [2:0]  JUMP_OP     = 3'h5;
	localparam logic [5:0]  INC_OP      = 6'h0a;
	localparam logic [5:0]  INCSKIP_OP  = 6'h0f;
	localparam int          JUMP_TOP    = 11;
	localparam int          JUMP_BOT    = 9;
	localparam int          OP6_TOP     = 11;
	localparam int          OP6_BOT     = 6;
	localparam int          DEST_BIT    = 5;
	localparam int          STAT_PG_HI  = 6;
	localparam int          STAT_PG_LO  = 5;
	localparam int          STAT_ZERO   = 2;
	localparam logic [7:0]  ONE         = 8'h01;
	localparam logic [7:0]  ZERO_BYTE   = 8'h00;
	localparam logic [7:0]  W_RESET     = 8'h00;
	localparam logic [10:0] PC_RESET    = 11'h000;
	localparam logic [1:0]  COUNT_RESET = 2'h0;
	localparam logic [1:0]  CYC_ONE     = 2'h1;
	localparam logic [1:0]  CYC_TWO     = 2'h2;
endpackage

// *** logic/jump_inc_exec.sv ***
// execute stage for the jump, add_one_to_file and add_one_skip_on_zero instructions
module jump_inc_exec (
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic        instr_valid,
	input  wire logic [11:0] instr_word,
	input  wire logic [7:0]  file_rdata,
	input  wire logic [7:0]  status_in,
	output logic      [4:0]  file_addr,
	output logic             file_we,
	output logic      [7:0]  file_wdata,
	output logic      [7:0]  w_reg,
	output logic             status_we,
	output logic      [7:0]  status_wdata,
	output logic             pc_load,
	output logic      [10:0] pc_target,
	output logic             flush,
	output logic             busy
);
	logic       rst_meta_reg;
	logic       rst_sync_reg;
	logic       is_jump;
	logic       is_inc;
	logic       is_skip;
	logic       dest_file;
	logic [7:0] sum;
	logic       sum_zero;
	logic [1:0] cyc_reg;

	// reset release through two flops; async assert
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// decode; a flushed slot (busy) is executed as a no-op
	assign is_jump   = instr_valid && !busy &&
		(instr_word[exec_pkg::JUMP_TOP:exec_pkg::JUMP_BOT] == exec_pkg::JUMP_OP);
	assign is_inc    = instr_valid && !busy &&
		(instr_word[exec_pkg::OP6_TOP:exec_pkg::OP6_BOT] == exec_pkg::INC_OP);
	assign is_skip   = instr_valid && !busy &&
		(instr_word[exec_pkg::OP6_TOP:exec_pkg::OP6_BOT] == exec_pkg::INCSKIP_OP);
	assign dest_file = instr_word[exec_pkg::DEST_BIT];
	assign sum       = file_rdata + exec_pkg::ONE; // wraps 0xff to 0x00
	assign sum_zero  = (sum == exec_pkg::ZERO_BYTE);

	// file address is combinational from the instruction, the read is asynchronous;
	// it is the one output not taken from a flop, since a registered address would
	// hand back the word of the previous slot
	assign file_addr = instr_word[4:0];

	// file write back
	always_ff @(posedge core_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			file_we    <= 1'b0;
			file_wdata <= exec_pkg::ZERO_BYTE;
		end else begin
			file_we    <= (is_inc || is_skip) && dest_file;
			file_wdata <= sum;
		end
	end

	// working register
	always_ff @(posedge core_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			w_reg <= exec_pkg::W_RESET;
		end else if ((is_inc || is_skip) && !dest_file) begin
			w_reg <= sum;
		end
	end

	// zero flag, only the plain increment touches status
	always_ff @(posedge core_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			status_we    <= 1'b0;
			status_wdata <= exec_pkg::ZERO_BYTE;
		end else begin
			status_we    <= is_inc;
			status_wdata <= status_in;
			status_wdata[exec_pkg::STAT_ZERO] <= sum_zero;
		end
	end

	// program counter load for the jump, unconditional
	always_ff @(posedge core_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			pc_load   <= 1'b0;
			pc_target <= exec_pkg::PC_RESET;
		end else begin
			pc_load   <= is_jump;
			pc_target <= {status_in[exec_pkg::STAT_PG_HI:exec_pkg::STAT_PG_LO],
				instr_word[8:0]};
		end
	end

	// flush of the prefetched word: jump always, skip only on a zero sum
	always_ff @(posedge core_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			flush   <= 1'b0;
			busy    <= 1'b0;
			cyc_reg <= exec_pkg::COUNT_RESET;
		end else begin
			flush   <= is_jump || (is_skip && sum_zero);
			busy    <= is_jump || (is_skip && sum_zero); // second cycle is a no-op
			cyc_reg <= (is_jump || (is_skip && sum_zero)) ? exec_pkg::CYC_TWO : exec_pkg::CYC_ONE;
		end
	end

	property p_jump_target;
		@(posedge core_clk) disable iff (!rst_sync_reg)
		is_jump |=> pc_load && (pc_target[8:0] == $past(instr_word[8:0]));
	endproperty
	a_jump_target: assert property (p_jump_target) else $error("jump low bits wrong");

	property p_jump_page;
		@(posedge core_clk) disable iff (!rst_sync_reg)
		is_jump |=> (pc_target[10:9] == $past(status_in[6:5]));
	endproperty
	a_jump_page: assert property (p_jump_page) else $error("jump page bits wrong");

	property p_jump_two;
		@(posedge core_clk) disable iff (!rst_sync_reg)
		is_jump |=> flush && busy ##1 !pc_load;
	endproperty
	a_jump_two: assert property (p_jump_two) else $error("jump not two cycles");

	property p_inc_w;
		@(posedge core_clk) disable iff (!rst_sync_reg)
		(is_inc && !dest_file) |=> (w_reg == $past(sum)) && !file_we;
	endproperty
	a_inc_w: assert property (p_inc_w) else $error("increment to w wrong");

	property p_inc_file;
		@(posedge core_clk) disable iff (!rst_sync_reg)
		((is_inc || is_skip) && dest_file) |=> file_we && $stable(w_reg);
	endproperty
	a_inc_file: assert property (p_inc_file) else $error("increment to file wrong");

	property p_skip_nz;
		@(posedge core_clk) disable iff (!rst_sync_reg)
		(is_skip && !sum_zero) |=> !flush;
	endproperty
	a_skip_nz: assert property (p_skip_nz) else $error("skip on nonzero");

	property p_skip_z;
		@(posedge core_clk) disable iff (!rst_sync_reg)
		(is_skip && sum_zero) |=> flush && (cyc_reg == exec_pkg::CYC_TWO);
	endproperty
	a_skip_z: assert property (p_skip_z) else $error("no skip on zero");

	property p_zflag;
		@(posedge core_clk) disable iff (!rst_sync_reg)
		is_inc |=> status_we && (status_wdata[2] == $past(sum_zero)) && !flush;
	endproperty
	a_zflag: assert property (p_zflag) else $error("zero flag wrong");

	property p_no_status;
		@(posedge core_clk) disable iff (!rst_sync_reg)
		(is_jump || is_skip) |=> !status_we;
	endproperty
	a_no_status: assert property (p_no_status) else $error("status touched");

	// further checks: the dropped slot, the data paths and the cycle counts;
	// each looks one edge after the slot is taken, when the flops show the answer

	property p_busy_noop;
		@(posedge core_clk) disable iff (!rst_sync_reg)
		busy |=> !file_we && !status_we && !pc_load && $stable(w_reg);
	endproperty
	a_busy_noop: assert property (p_busy_noop) else $error("dropped slot not a no-op");

	property p_file_data;
		@(posedge core_clk) disable iff (!rst_sync_reg)
		((is_inc || is_skip) && dest_file) |=> (file_wdata == $past(file_rdata) + exec_pkg::ONE);
	endproperty
	a_file_data: assert property (p_file_data) else $error("file write data wrong");

	property p_skip_w;
		@(posedge core_clk) disable iff (!rst_sync_reg)
		(is_skip && !dest_file) |=> (w_reg == $past(file_rdata) + exec_pkg::ONE) && !file_we;
	endproperty
	a_skip_w: assert property (p_skip_w) else $error("skip to w wrong");

	property p_zflag_rest;
		@(posedge core_clk) disable iff (!rst_sync_reg)
		is_inc |=> (status_wdata[7:3] == $past(status_in[7:3])) &&
			(status_wdata[1:0] == $past(status_in[1:0]));
	endproperty
	a_zflag_rest: assert property (p_zflag_rest) else $error("other status bits changed");

	property p_inc_one;
		@(posedge core_clk) disable iff (!rst_sync_reg)
		is_inc |=> !busy && (cyc_reg == exec_pkg::CYC_ONE);
	endproperty
	a_inc_one: assert property (p_inc_one) else $error("increment not one cycle");

	property p_skip_nz_one;
		@(posedge core_clk) disable iff (!rst_sync_reg)
		(is_skip && !sum_zero) |=> !busy && (cyc_reg == exec_pkg::CYC_ONE);
	endproperty
	a_skip_nz_one: assert property (p_skip_nz_one) else $error("nonzero skip not one cycle");

	property p_jump_cyc;
		@(posedge core_clk) disable iff (!rst_sync_reg)
		is_jump |=> (cyc_reg == exec_pkg::CYC_TWO) && !file_we;
	endproperty
	a_jump_cyc: assert property (p_jump_cyc) else $error("jump cycle count wrong");

	property p_inc_no_jump;
		@(posedge core_clk) disable iff (!rst_sync_reg)
		(is_inc || is_skip) |=> !pc_load;
	endproperty
	a_inc_no_jump: assert property (p_inc_no_jump) else $error("increment loaded the pc");

	property p_flush_pulse;
		@(posedge core_clk) disable iff (!rst_sync_reg)
		flush |=> !flush;
	endproperty
	a_flush_pulse: assert property (p_flush_pulse) else $error("flush longer than a cycle");
endmodule

// *** tb/tb.sv ***
// self-checking bench for the jump and increment execute block
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic        core_clk    = 1'b0;
	logic        rstn        = 1'b0;
	logic        instr_valid = 1'b0;
	logic [11:0] instr_word  = 12'h000;
	logic [7:0]  file_rdata  = 8'h00;
	logic [7:0]  status_in   = 8'h00;
	logic [4:0]  file_addr;
	logic        file_we;
	logic [7:0]  file_wdata;
	logic [7:0]  w_reg;
	logic        status_we;
	logic [7:0]  status_wdata;
	logic        pc_load;
	logic [10:0] pc_target;
	logic        flush;
	logic        busy;
	int          mismatches = 0;
	int          n_checks   = 0;
	int          cycles     = 0;
	// 20 mhz core clock
	always #25 core_clk = ~core_clk;
	jump_inc_exec jump_inc_exec_i (.core_clk(core_clk), .rstn(rstn), .instr_valid(instr_valid),
		.instr_word(instr_word), .file_rdata(file_rdata), .status_in(status_in),
		.file_addr(file_addr), .file_we(file_we), .file_wdata(file_wdata), .w_reg(w_reg),
		.status_we(status_we), .status_wdata(status_wdata), .pc_load(pc_load),
		.pc_target(pc_target), .flush(flush), .busy(busy));
	// compare one value, wide enough for the pc
	task automatic chk(string name, logic [10:0] seen, logic [10:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// present one slot; checks after it see the flops' answer to the previous slot, and file_addr for the present one
	task automatic drv(logic v, logic [11:0] i, logic [7:0] r, logic [7:0] s);
		@(posedge core_clk);
		instr_valid <= v;
		instr_word  <= i;
		file_rdata  <= r;
		status_in   <= s;
		#1;
	endtask
	// two jumps on different pages; the increment in the flushed slot must be dropped
	task automatic t_jump();
		drv(1'b1, 12'ha05, 8'h00, 8'h60);
		drv(1'b1, 12'h283, 8'h7f, 8'h60);
		chk("pc_target", pc_target, 11'h605);
		chk("pc_load", pc_load, 11'h001);
		chk("flush", flush, 11'h001);
		chk("busy", busy, 11'h001);
		chk("status_we", status_we, 11'h000);
		drv(1'b1, 12'hbaa, 8'h00, 8'hdf);
		chk("w_reg", w_reg, 11'h000);
		chk("pc_load", pc_load, 11'h000);
		chk("flush", flush, 11'h000);
		chk("busy", busy, 11'h000);
		drv(1'b0, 12'h000, 8'h00, 8'h00);
		chk("pc_target", pc_target, 11'h5aa);
		chk("pc_load", pc_load, 11'h001);
		chk("status_we", status_we, 11'h000);
		drv(1'b0, 12'h000, 8'h00, 8'h00);
		chk("pc_load", pc_load, 11'h000);
		chk("flush", flush, 11'h000);
		$display("jump test done");
	endtask
	// back to back increments: to w, to the file register, then to w with a zero sum
	task automatic t_inc();
		drv(1'b1, 12'h283, 8'h7f, 8'h04);
		chk("file_addr", file_addr, 11'h003);
		drv(1'b1, 12'h2a3, 8'h41, 8'h60);
		chk("w_reg", w_reg, 11'h080);
		chk("file_we", file_we, 11'h000);
		chk("status_we", status_we, 11'h001);
		chk("status_wdata", status_wdata, 11'h000);
		chk("busy", busy, 11'h000);
		drv(1'b1, 12'h283, 8'hff, 8'h60);
		chk("file_wdata", file_wdata, 11'h042);
		chk("file_we", file_we, 11'h001);
		chk("status_wdata", status_wdata, 11'h060);
		chk("w_reg", w_reg, 11'h080);
		drv(1'b0, 12'h000, 8'h00, 8'h00);
		chk("w_reg", w_reg, 11'h000);
		chk("status_wdata", status_wdata, 11'h064);
		chk("file_we", file_we, 11'h000);
		$display("increment test done");
	endtask
	// zero result skips the next slot, a nonzero one does not
	task automatic t_skip();
		drv(1'b1, 12'h3e7, 8'hff, 8'h00);
		drv(1'b1, 12'h3c7, 8'h10, 8'h00);
		chk("file_wdata", file_wdata, 11'h000);
		chk("flush", flush, 11'h001);
		chk("busy", busy, 11'h001);
		chk("status_we", status_we, 11'h000);
		chk("file_we", file_we, 11'h001);
		drv(1'b1, 12'h3c7, 8'h10, 8'h00);
		chk("w_reg", w_reg, 11'h000);
		drv(1'b0, 12'h000, 8'h00, 8'h00);
		chk("w_reg", w_reg, 11'h011);
		chk("flush", flush, 11'h000);
		$display("skip test done");
	endtask
	// reset in mid-run clears w, and an increment works again after release
	task automatic t_reset();
		@(posedge core_clk);
		rstn <= 1'b0;
		#1;
		chk("w_reg", w_reg, 11'h000);
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge core_clk);
		drv(1'b1, 12'h283, 8'h05, 8'h00);
		drv(1'b0, 12'h000, 8'h00, 8'h00);
		chk("w_reg", w_reg, 11'h006);
		$display("reset test done");
	endtask
	// print counts and verdict, then stop
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// hang guard, far above the few dozen cycles the tests need
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 400) begin
			mismatches++;
			results();
		end
	end
	// reset, then the scenarios
	initial begin
		repeat (6) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge core_clk);
		t_jump();
		t_inc();
		t_skip();
		t_reset();
		results();
	end
endmodule
